// *** hdl/dmc_regs.sv ***
// mode-control register bank with 16-bit serial control port
// assumes ctl_sck sampled on mclk, frame_clock pulses synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
`include "dmc_defs.svh"
module dmc_regs
  import dmc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ctl_cs_n,
  input  wire logic       ctl_sck,
  input  wire logic       ctl_sdi,
  output logic            ctl_sdo_q,
  input  wire logic       frame_clock,
  input  wire logic       bitstream_mode,
  input  wire logic       filter_bypass_mode,
  input  wire logic       sample_tick,
  input  wire logic       left_zero,
  input  wire logic       right_zero,
  input  wire logic       left_bitstream_pin_i,
  input  wire logic       right_bitstream_pin_i,
  output logic            left_bitstream_pin_o_q,
  output logic            right_bitstream_pin_o_q,
  output logic            left_bitstream_pin_oe_q,
  output logic            right_bitstream_pin_oe_q,
  input  wire logic       bypass_data_pin,
  output logic            left_data_q,
  output logic            right_data_q,
  output logic [7:0]      left_level_q,
  output logic [7:0]      right_level_q,
  output logic            left_mute_q,
  output logic            right_mute_q,
  output logic [2:0]      audio_format_sel_q,
  output logic [1:0]      deemph_freq_sel_q,
  output logic            deemph_active_q,
  output logic [1:0]      fir_response_sel_q,
  output logic            output_phase_invert_q,
  output logic            bipolar_zero_level_q,
  output logic            rolloff_sel_q,
  output logic            bypass_mono_q
);
  // register fields
  logic [7:0] left_atten_code_q, right_atten_code_q;
  logic [7:0] left_tgt_q, right_tgt_q;
  logic       atten_load_enable_q, deemph_enable_q, soft_mute_q;
  logic [1:0] atten_rate_sel_q;
  logic       analog_output_disable_q, zero_flag_pin_sel_q;
  logic       bypass_stereo_sel_q, zero_detect_mute_en_q;
  dmc_fmt_t   fmt_q;
  logic [1:0] dmf_q;
  logic       rev_q, flt_q;
  // serial port
  dmc_state_t state_q, state_d;
  logic [15:0] sh_q;
  logic [4:0]  cnt_q;
  logic        sck_d1_q;
  logic [7:0]  rd_q;
  wire sck_rise = ctl_sck && !sck_d1_q;
  wire sck_fall = !ctl_sck && sck_d1_q;
  wire [15:0] sh_next = {sh_q[14:0], ctl_sdi};
  wire word_done = (state_q == DMC_SHIFT) && sck_rise
                   && (cnt_q == 5'(`DMC_WORD_BITS - 1));
  wire [6:0] addr_early = sh_next[6:0];
  wire [6:0] wr_addr = sh_next[14:8];
  wire [7:0] wr_data = sh_next[7:0];
  wire wr_left  = word_done && !sh_next[`DMC_RW_BIT] && wr_addr == `DMC_REG_LEFT;
  wire wr_right = word_done && !sh_next[`DMC_RW_BIT] && wr_addr == `DMC_REG_RIGHT;
  wire wr_fmt   = word_done && !sh_next[`DMC_RW_BIT] && wr_addr == `DMC_REG_FMT;
  wire wr_out   = word_done && !sh_next[`DMC_RW_BIT] && wr_addr == `DMC_REG_OUT;
  wire [7:0] reg_fmt = {atten_load_enable_q, fmt_q, dmf_q, deemph_enable_q, soft_mute_q};
  wire [7:0] reg_out = {rev_q, atten_rate_sel_q, analog_output_disable_q,
                        zero_flag_pin_sel_q, bypass_stereo_sel_q, flt_q,
                        zero_detect_mute_en_q};
  wire [7:0] rd_mux = (addr_early == `DMC_REG_LEFT)  ? left_atten_code_q :
                      (addr_early == `DMC_REG_RIGHT) ? right_atten_code_q :
                      (addr_early == `DMC_REG_FMT)   ? reg_fmt :
                      (addr_early == `DMC_REG_OUT)   ? reg_out : 8'h00;
  wire load_rd = (state_q == DMC_SHIFT) && sck_rise && (cnt_q == 5'h07)
                 && sh_q[6];
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      DMC_IDLE:  state_d = ctl_cs_n ? DMC_IDLE : DMC_SHIFT;
      DMC_SHIFT: state_d = ctl_cs_n ? DMC_IDLE : (word_done ? DMC_DONE : DMC_SHIFT);
      DMC_DONE:  state_d = ctl_cs_n ? DMC_IDLE : DMC_DONE;
      default:   state_d = DMC_IDLE;
    endcase
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q  <= DMC_IDLE;
      sh_q     <= 16'h0000;
      cnt_q    <= 5'h00;
      sck_d1_q <= 1'b0;
      rd_q     <= 8'h00;
      ctl_sdo_q <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      sck_d1_q <= ctl_sck;
      if (state_q == DMC_IDLE)
      begin
        cnt_q <= 5'h00;
        sh_q  <= 16'h0000;
      end
      else if (sck_rise && state_q == DMC_SHIFT)
      begin
        sh_q  <= sh_next;
        cnt_q <= cnt_q + 5'h01;
      end
      if (load_rd)
        rd_q <= rd_mux;
      else if (sck_fall && cnt_q > 5'h08)
        rd_q <= {rd_q[6:0], 1'b0};
      ctl_sdo_q <= (cnt_q > 5'h08) ? rd_q[7] : 1'b0;
    end
  end
  // register writes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      left_atten_code_q  <= `DMC_ATT_RST;
      right_atten_code_q <= `DMC_ATT_RST;
      atten_load_enable_q <= 1'b0;
      fmt_q <= dmc_fmt_t'(`DMC_FMT_RST);
      dmf_q <= 2'h0;
      deemph_enable_q <= 1'b0;
      soft_mute_q <= 1'b0;
      rev_q <= 1'b0;
      atten_rate_sel_q <= 2'h0;
      analog_output_disable_q <= 1'b0;
      zero_flag_pin_sel_q <= 1'b0;
      bypass_stereo_sel_q <= 1'b0;
      flt_q <= 1'b0;
      zero_detect_mute_en_q <= 1'b0;
    end
    else
    begin
      if (wr_left)
        left_atten_code_q <= wr_data;
      if (wr_right)
        right_atten_code_q <= wr_data;
      if (wr_fmt)
      begin
        atten_load_enable_q <= wr_data[7];
        fmt_q               <= dmc_fmt_t'(wr_data[6:4]);
        {dmf_q, deemph_enable_q, soft_mute_q} <= wr_data[3:0];
      end
      if (wr_out)
        {rev_q, atten_rate_sel_q, analog_output_disable_q, zero_flag_pin_sel_q,
         bypass_stereo_sel_q, flt_q, zero_detect_mute_en_q} <= wr_data;
    end
  end
  // targets latch only while load is enabled
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      left_tgt_q  <= `DMC_ATT_RST;
      right_tgt_q <= `DMC_ATT_RST;
    end
    else if (atten_load_enable_q)
    begin
      left_tgt_q  <= left_atten_code_q;
      right_tgt_q <= right_atten_code_q;
    end
  end
  // step-rate divider on frame clock edges
  logic       fc_d1_q;
  logic [2:0] div_q;
  wire fc_rise = frame_clock && !fc_d1_q;
  wire [2:0] div_max = (atten_rate_sel_q == 2'h0) ? 3'h0 :
                       (atten_rate_sel_q == 2'h1) ? 3'h1 :
                       (atten_rate_sel_q == 2'h2) ? 3'h3 : 3'h7;
  wire step_en = fc_rise && (div_q >= div_max);
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fc_d1_q <= 1'b0;
      div_q   <= 3'h0;
    end
    else
    begin
      fc_d1_q <= frame_clock;
      if (fc_rise)
        div_q <= (div_q >= div_max) ? 3'h0 : div_q + 3'h1;
    end
  end
  // soft mute drives the ramp toward code zero
  wire [7:0] left_goal  = soft_mute_q ? 8'h00 : left_tgt_q;
  wire [7:0] right_goal = soft_mute_q ? 8'h00 : right_tgt_q;
  logic [7:0] left_lvl, right_lvl;
  dmc_ramp u_left (.mclk(mclk), .rst(rst), .step_en(step_en),
                   .target(left_goal), .level_q(left_lvl));
  dmc_ramp u_right (.mclk(mclk), .rst(rst), .step_en(step_en),
                    .target(right_goal), .level_q(right_lvl));
  // zero-run detector
  logic [10:0] zrun_q;
  wire zero_held = zrun_q == `DMC_ZERO_RUN;
  always_ff @(posedge mclk)
  begin
    if (rst)
      zrun_q <= 11'h000;
    else if (sample_tick)
      zrun_q <= !(left_zero && right_zero) ? 11'h000 :
                (zero_held ? zrun_q : zrun_q + 11'h001);
  end
  wire bpz_d = analog_output_disable_q
               || (zero_detect_mute_en_q && zero_held && !bitstream_mode);
  wire stereo_in = filter_bypass_mode && bypass_stereo_sel_q;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      left_level_q <= `DMC_ATT_RST;
      right_level_q <= `DMC_ATT_RST;
      left_mute_q <= 1'b0;
      right_mute_q <= 1'b0;
      audio_format_sel_q <= `DMC_FMT_RST;
      deemph_freq_sel_q <= 2'h0;
      deemph_active_q <= 1'b0;
      fir_response_sel_q <= 2'h0;
      output_phase_invert_q <= 1'b0;
      bipolar_zero_level_q <= 1'b0;
      rolloff_sel_q <= 1'b0;
      bypass_mono_q <= 1'b1;
      left_bitstream_pin_o_q <= 1'b0;
      right_bitstream_pin_o_q <= 1'b0;
      left_bitstream_pin_oe_q <= 1'b0;
      right_bitstream_pin_oe_q <= 1'b0;
      left_data_q <= 1'b0;
      right_data_q <= 1'b0;
    end
    else
    begin
      left_level_q <= left_lvl;
      right_level_q <= right_lvl;
      left_mute_q <= left_lvl <= `DMC_ATT_MUTE_MAX;
      right_mute_q <= right_lvl <= `DMC_ATT_MUTE_MAX;
      audio_format_sel_q <= fmt_q;
      deemph_freq_sel_q <= bitstream_mode ? 2'h0 : dmf_q;
      deemph_active_q <= deemph_enable_q && !bitstream_mode;
      fir_response_sel_q <= bitstream_mode ? dmf_q : 2'h0;
      output_phase_invert_q <= rev_q;
      bipolar_zero_level_q <= bpz_d;
      rolloff_sel_q <= flt_q;
      bypass_mono_q <= filter_bypass_mode && !bypass_stereo_sel_q;
      left_bitstream_pin_oe_q <= zero_flag_pin_sel_q;
      right_bitstream_pin_oe_q <= zero_flag_pin_sel_q;
      left_bitstream_pin_o_q <= zero_flag_pin_sel_q && left_zero;
      right_bitstream_pin_o_q <= zero_flag_pin_sel_q && right_zero;
      left_data_q <= (filter_bypass_mode && !stereo_in) ? bypass_data_pin
                     : (zero_flag_pin_sel_q ? 1'b0 : left_bitstream_pin_i);
      right_data_q <= (filter_bypass_mode && !stereo_in) ? bypass_data_pin
                      : (zero_flag_pin_sel_q ? 1'b0 : right_bitstream_pin_i);
    end
  end
  wr_left_a: assert property (@(posedge mclk) disable iff (rst)
    wr_left |=> left_atten_code_q == $past(wr_data))
    else $error("left code not stored");
  load_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !atten_load_enable_q |=> left_tgt_q == $past(left_tgt_q))
    else $error("target changed while load disabled");
  read_keep_a: assert property (@(posedge mclk) disable iff (rst)
    word_done && sh_next[`DMC_RW_BIT] |=> $stable(reg_fmt) && $stable(reg_out))
    else $error("read altered registers");
  mute_goal_a: assert property (@(posedge mclk) disable iff (rst)
    soft_mute_q && step_en && left_lvl != 8'h00 |=> left_lvl == $past(left_lvl) - 8'h01)
    else $error("soft mute not stepping down");
  opd_bpz_a: assert property (@(posedge mclk) disable iff (rst)
    analog_output_disable_q |=> bipolar_zero_level_q)
    else $error("output disable not forcing zero");
  pin_dir_a: assert property (@(posedge mclk) disable iff (rst)
    zero_flag_pin_sel_q |=> left_bitstream_pin_oe_q && right_bitstream_pin_oe_q)
    else $error("zero flag pins not driven");
  mute_code_a: assert property (@(posedge mclk) disable iff (rst)
    left_lvl == 8'h0f |=> !left_mute_q)
    else $error("code 15 muted");
  phase_a: assert property (@(posedge mclk) disable iff (rst)
    rev_q |=> output_phase_invert_q)
    else $error("phase invert lost");
  deemph_a: assert property (@(posedge mclk) disable iff (rst)
    deemph_enable_q && !bitstream_mode |=> deemph_active_q)
    else $error("de-emphasis not enabled");
endmodule // dmc_regs
`default_nettype wire

// *** common/dmc_defs.svh ***
// constants of the mode-control register bank
// assumes inclusion by bare name from design files
`ifndef DMC_DEFS_SVH
`define DMC_DEFS_SVH
`define DMC_REG_LEFT      7'h10
`define DMC_REG_RIGHT     7'h11
`define DMC_REG_FMT       7'h12
`define DMC_REG_OUT       7'h13
`define DMC_ATT_RST       8'hff
`define DMC_ATT_MUTE_MAX  8'h0e
`define DMC_FMT_RST       3'h5
`define DMC_WORD_BITS     16
`define DMC_RW_BIT        15
`define DMC_ZERO_RUN      11'h400
`endif

// *** common/dmc_pkg.sv ***
// types of the mode-control register bank
// assumes nothing beyond the compiler
package dmc_pkg;
  typedef enum logic [2:0] {
    DMC_FMT_RJ16 = 3'h0, DMC_FMT_RJ20 = 3'h1, DMC_FMT_RJ24 = 3'h2,
    DMC_FMT_LJ24 = 3'h3, DMC_FMT_I2S16 = 3'h4, DMC_FMT_I2S24 = 3'h5,
    DMC_FMT_RSV6 = 3'h6, DMC_FMT_RSV7 = 3'h7
  } dmc_fmt_t;
  typedef enum logic [2:0] {
    DMC_IDLE = 3'b001,
    DMC_SHIFT = 3'b010,
    DMC_DONE = 3'b100
  } dmc_state_t;
endpackage

// *** hdl/dmc_ramp.sv ***
// one attenuator ramp: steps the applied code one 0.5 dB step per tick
// assumes step_en is a one-cycle pulse on mclk
`timescale 1ns/1ps
`default_nettype none
`include "dmc_defs.svh"
module dmc_ramp
  import dmc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       step_en,
  input  wire logic [7:0] target,
  output logic      [7:0] level_q
);
  wire up   = level_q < target;
  wire down = level_q > target;
  always_ff @(posedge mclk)
  begin
    if (rst)
      level_q <= `DMC_ATT_RST;
    else if (step_en && up)
      level_q <= level_q + 8'h01;
    else if (step_en && down)
      level_q <= level_q - 8'h01;
  end
  step_bound_a: assert property (@(posedge mclk) disable iff (rst)
    !step_en |=> level_q == $past(level_q))
    else $error("level moved without step");
endmodule // dmc_ramp
`default_nettype wire

// *** tb/dmc_host.sv ***
// host controller model on the serial control port
// assumes the bench shares mclk; one word per select window
`timescale 1ns/1ps
`default_nettype none
module dmc_host
(
  input  wire logic mclk,
  output logic      ctl_cs_n,
  output logic      ctl_sck,
  output logic      ctl_sdi,
  input  wire logic ctl_sdo_q
);
  initial
  begin
    ctl_cs_n = 1'b1;
    ctl_sck  = 1'b0;
    ctl_sdi  = 1'b1;
  end
  // sck low two mclk, high three; data set while sck low
  task automatic xfer(input logic rd, input logic [6:0] adr, input logic [7:0] dat,
                      output logic [7:0] rdat);
    logic [15:0] word;
    word = {rd, adr, dat};
    rdat = 8'h00;
    @(posedge mclk);
    ctl_cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      ctl_sdi <= word[i];
      repeat (2) @(posedge mclk);
      ctl_sck <= 1'b1;
      // read bit stands from two mclk after the rise until two mclk after the fall
      repeat (3) @(posedge mclk);
      if (i < 8)
        rdat[i] = ctl_sdo_q;
      ctl_sck <= 1'b0;
    end
    repeat (2) @(posedge mclk);
    ctl_cs_n <= 1'b1;
    // released data line must not hold its last value
    ctl_sdi  <= ~ctl_sdi;
  endtask
endmodule // dmc_host
`default_nettype wire

// *** tb/dac_mode_control_regs_tb.sv ***
// self-checking bench for the mode-control register bank
// assumes dmc_host as the control port master, mclk at 40 MHz
`timescale 1ns/1ps
`default_nettype none
module dac_mode_control_regs_tb;
  typedef struct packed {logic [6:0] adr; logic [7:0] dat; logic [10:0] exp;} dmc_row_t;
  logic       mclk = 1'b0, rst = 1'b1, frame_clock = 1'b0, sample_tick = 1'b0;
  logic       bitstream_mode = 1'b0, filter_bypass_mode = 1'b1;
  logic       left_zero = 1'b0, right_zero = 1'b0;
  logic       bypass_data_pin = 1'b0, left_bs_i = 1'b0, right_bs_i = 1'b0;
  logic       ctl_cs_n, ctl_sck, ctl_sdi, ctl_sdo_q, left_data_q, right_data_q;
  logic       lpo, rpo, lpoe, rpoe, left_mute_q, right_mute_q, deemph_active_q;
  logic       output_phase_invert_q, bipolar_zero_level_q, rolloff_sel_q, bypass_mono_q;
  logic [7:0] left_level_q, right_level_q;
  logic [2:0] audio_format_sel_q;
  logic [1:0] deemph_freq_sel_q, fir_response_sel_q;
  logic [2:0] div_q = 3'h0;
  int         error_cnt = 0;
  int         compares = 0;
  wire logic [10:0] obs = {audio_format_sel_q, deemph_freq_sel_q, deemph_active_q,
    output_phase_invert_q, bipolar_zero_level_q, rolloff_sel_q, bypass_mono_q, lpoe};
  // no reserved format code is ever written
  dmc_row_t rows [11] = '{
    '{7'h12, 8'h00, 11'h002}, '{7'h12, 8'h16, 11'h162}, '{7'h12, 8'h2a, 11'h2a2},
    '{7'h12, 8'h3e, 11'h3e2}, '{7'h12, 8'h40, 11'h402}, '{7'h12, 8'h50, 11'h502},
    '{7'h13, 8'h80, 11'h512}, '{7'h13, 8'h10, 11'h50a}, '{7'h13, 8'h0e, 11'h505},
    '{7'h13, 8'h60, 11'h502}, '{7'h13, 8'h00, 11'h502}};

  dmc_regs dut_u (
    .mclk(mclk), .rst(rst), .ctl_cs_n(ctl_cs_n), .ctl_sck(ctl_sck), .ctl_sdi(ctl_sdi),
    .ctl_sdo_q(ctl_sdo_q), .frame_clock(frame_clock), .bitstream_mode(bitstream_mode),
    .filter_bypass_mode(filter_bypass_mode), .sample_tick(sample_tick),
    .left_zero(left_zero), .right_zero(right_zero), .left_bitstream_pin_i(left_bs_i),
    .right_bitstream_pin_i(right_bs_i), .left_bitstream_pin_o_q(lpo),
    .right_bitstream_pin_o_q(rpo), .left_bitstream_pin_oe_q(lpoe),
    .right_bitstream_pin_oe_q(rpoe), .bypass_data_pin(bypass_data_pin),
    .left_data_q(left_data_q), .right_data_q(right_data_q), .left_level_q(left_level_q),
    .right_level_q(right_level_q), .left_mute_q(left_mute_q), .right_mute_q(right_mute_q),
    .audio_format_sel_q(audio_format_sel_q), .deemph_freq_sel_q(deemph_freq_sel_q),
    .deemph_active_q(deemph_active_q), .fir_response_sel_q(fir_response_sel_q),
    .output_phase_invert_q(output_phase_invert_q), .rolloff_sel_q(rolloff_sel_q),
    .bipolar_zero_level_q(bipolar_zero_level_q), .bypass_mono_q(bypass_mono_q));
  dmc_host host_u (.mclk(mclk), .ctl_cs_n(ctl_cs_n), .ctl_sck(ctl_sck), .ctl_sdi(ctl_sdi),
    .ctl_sdo_q(ctl_sdo_q));

  initial
  begin
    forever #12.5 mclk = ~mclk;
  end
  // frame clock of 8 mclk, one sample tick per frame
  always @(posedge mclk)
  begin
    div_q       <= div_q + 3'h1;
    frame_clock <= div_q[2];
    sample_tick <= div_q == 3'h3;
  end

  task automatic give_verdict;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] adr, input logic [7:0] dat);
    logic [7:0] r;
    host_u.xfer(1'b0, adr, dat, r);
    repeat (3) @(posedge mclk);
  endtask
  task automatic rd_chk(input logic [6:0] adr, input logic [7:0] exp);
    logic [7:0] r;
    host_u.xfer(1'b1, adr, 8'h00, r);
    check(r, exp);
  endtask
  // follows one applied level, every move must be a single code
  task automatic watch(input logic lft, input logic [7:0] start, input logic [7:0] target,
                       input int gap);
    logic [7:0] prev;
    logic [7:0] lv;
    int         n;
    int         t1;
    prev = start;
    n = 0;
    t1 = 0;
    for (int c = 0; c < 6000 && prev !== target; c++)
    begin
      @(posedge mclk);
      lv = lft ? left_level_q : right_level_q;
      if (lv !== prev)
      begin
        check(lv > prev ? lv - prev : prev - lv, 16'h0001);
        n++;
        if (n == 2 && gap != 0)
          check(16'(c - t1), 16'(gap));
        t1 = c;
        prev = lv;
      end
    end
    if (prev !== target)
    begin
      error_cnt++;
      give_verdict();
    end
    check(16'(n), start > target ? start - target : target - start);
  endtask

  initial
  begin
    int n;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (rows[i])
    begin
      wr(rows[i].adr, rows[i].dat);
      check(obs, rows[i].exp);
      rd_chk(rows[i].adr, rows[i].dat);
    end
    $display("table test done");
    rst <= 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    check({left_level_q, right_level_q}, 16'hffff);
    check(obs, 11'h502);
    rd_chk(7'h12, 8'h50);
    rd_chk(7'h13, 8'h00);
    $display("reset test done");
    wr(7'h10, 8'h80);
    repeat (24) @(posedge mclk);
    check(left_level_q, 8'hff);
    rd_chk(7'h10, 8'h80);
    rd_chk(7'h11, 8'hff);
    fork
      wr(7'h12, 8'hd0);
      watch(1'b1, 8'hff, 8'h80, 0);
    join
    wr(7'h13, 8'h60);
    fork
      wr(7'h10, 8'h7d);
      watch(1'b1, 8'h80, 8'h7d, 64);
    join
    wr(7'h13, 8'h00);
    fork
      wr(7'h11, 8'h0e);
      watch(1'b0, 8'hff, 8'h0e, 0);
    join
    check({left_mute_q, right_mute_q}, 2'b01);
    fork
      wr(7'h12, 8'hd1);
      watch(1'b1, 8'h7d, 8'h00, 0);
    join
    check(left_mute_q, 1'b1);
    $display("ramp test done");
    wr(7'h05, 8'h33);
    rd_chk(7'h14, 8'h00);
    rd_chk(7'h12, 8'hd1);
    bitstream_mode <= 1'b1;
    wr(7'h12, 8'hd9);
    check(fir_response_sel_q, 2'b10);
    bitstream_mode <= 1'b0;
    $display("unmapped and bitstream test done");
    bypass_data_pin <= 1'b1;
    right_bs_i      <= 1'b1;
    wr(7'h13, 8'h04);
    check({left_data_q, right_data_q}, 2'b01);
    wr(7'h13, 8'h00);
    check({left_data_q, right_data_q}, 2'b11);
    left_zero <= 1'b1;
    wr(7'h13, 8'h0c);
    check({lpo, rpo, lpoe, rpoe, left_data_q, right_data_q}, 6'h2c);
    $display("pin test done");
    wr(7'h13, 8'h01);
    left_zero  <= 1'b1;
    right_zero <= 1'b1;
    n = 0;
    while (bipolar_zero_level_q !== 1'b1 && n < 1100)
    begin
      @(posedge mclk);
      n += int'(sample_tick);
    end
    check(n > 1020 && n < 1028, 1'b1);
    $display("zero detect test done");
    give_verdict();
  end
endmodule // dac_mode_control_regs_tb
`default_nettype wire
